// ===== design/avc_volume_ctrl.sv
// Audio volume, mute, source and strap control with an AXI4-Lite register slave.
`include "avc_cfg.svh"
module avc_volume_ctrl
(
  // Clock and reset
  input  wire logic                CLK,
  input  wire logic                NRST,
  // AXI4-Lite write address
  input  wire logic [31:0]         S_AXI_AWADDR,
  input  wire logic                S_AXI_AWVALID,
  output logic                     S_AXI_AWREADY,
  // AXI4-Lite write data
  input  wire logic [31:0]         S_AXI_WDATA,
  input  wire logic [3:0]          S_AXI_WSTRB,
  input  wire logic                S_AXI_WVALID,
  output logic                     S_AXI_WREADY,
  // AXI4-Lite write response
  output logic [1:0]               S_AXI_BRESP,
  output logic                     S_AXI_BVALID,
  input  wire logic                S_AXI_BREADY,
  // AXI4-Lite read address
  input  wire logic [31:0]         S_AXI_ARADDR,
  input  wire logic                S_AXI_ARVALID,
  output logic                     S_AXI_ARREADY,
  // AXI4-Lite read data
  output logic [31:0]              S_AXI_RDATA,
  output logic [1:0]               S_AXI_RRESP,
  output logic                     S_AXI_RVALID,
  input  wire logic                S_AXI_RREADY,
  // Strap and pulse pins
  input  wire logic                HOST_PORT_DISABLE,
  input  wire logic                CLOCK_SOURCE_SELECT,
  input  wire logic                SDA,
  input  wire logic                SCL,
  input  wire logic                FRAME_CLOCK_OUT_PIN,
  input  wire logic                BIT_CLOCK_OUT_PIN,
  input  wire logic                MUTE,
  // Audio sources
  input  wire avc_pkg::avc_frame_t SERIAL_FRAME,
  input  wire logic                SERIAL_VALID,
  input  wire avc_pkg::avc_frame_t ADC_FRAME,
  input  wire logic                ADC_VALID,
  output logic                     AUDIO_READY,
  // Audio to the modulator
  output avc_pkg::avc_frame_t      OUT_FRAME,
  output logic                     OUT_VALID,
  input  wire logic                OUT_READY,
  // Modulator and clocking controls
  output logic                     CLOCK_FROM_MASTER_PIN,
  output logic                     MODULATION_PHASE_SHIFT,
  output logic                     SOURCE_IS_SERIAL,
  output logic [3:0]               SERIAL_RATE,
  output logic [3:0]               ADC_RATE
);

  localparam int SYNC_W = 7;
  localparam int HPD    = 0;
  localparam int CSEL   = 1;
  localparam int PDATA  = 2;
  localparam int PCLK   = 3;
  localparam int VUP    = 4;
  localparam int VDN    = 5;
  localparam int PMUTE  = 6;

  logic [SYNC_W-1:0]    sync1_reg;
  logic [SYNC_W-1:0]    sync2_reg;
  logic [SYNC_W-1:0]    sync3_reg;
  logic                 strap_mode;
  logic                 vol_up_edge;
  logic                 vol_dn_edge;
  logic                 vol_both;

  logic [7:0]           left_gain_reg;
  logic [7:0]           right_gain_reg;
  logic [7:0]           master_gain_reg;
  logic [31:0]          control_reg;
  logic [`AVC_RAMP_W-1:0] ramp_reg;

  logic [`AVC_ADDR_W-1:0] wr_addr_reg;
  logic [31:0]          wr_data_reg;
  logic [3:0]           wr_strb_reg;
  logic                 aw_got_reg;
  logic                 w_got_reg;
  logic                 wr_fire;
  logic                 wr_mapped;

  avc_pkg::avc_src_t    src_sel;
  avc_pkg::avc_mode_t   mode_sel;
  logic                 muted;
  logic                 in_valid;
  avc_pkg::avc_frame_t  in_frame;
  logic                 accept;

  avc_stream_if         core_s ();
  avc_stream_if         out_s ();

  // Saturating step of a gain code; a lower code is a louder setting.
  function automatic logic [7:0] step_gain(input logic [7:0] code, input logic louder);
    logic [7:0] res;
    res = code;
    if (louder && code != `AVC_GAIN_MIN_CODE)
      res = code - 8'h01;
    else if (!louder && code != `AVC_GAIN_MAX_CODE)
      res = code + 8'h01;
    return res;
  endfunction

  // Merge write strobes into a stored word, byte by byte.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        res[8*i +: 8] = data[8*i +: 8];
    return res;
  endfunction

  // Clamp a sample rate code to the highest code the path supports.
  function automatic logic [3:0] clamp_rate(input logic [3:0] code, input logic [3:0] top);
    return (code > top) ? top : code;
  endfunction

  // Apply channel plus master attenuation and the soft mute ramp to one sample.
  // Gain is applied in 6 dB shifts; finer steps are carried in the codes only,
  // which keeps the path free of a dB table at the cost of coarse resolution.
  function automatic avc_pkg::avc_sample_t scale(input avc_pkg::avc_sample_t smp,
                                                 input logic [7:0] chan,
                                                 input logic [7:0] master,
                                                 input logic [`AVC_RAMP_W-1:0] ramp);
    logic [8:0]         atten;
    logic [8:0]         shift;
    logic signed [23:0] ext;
    logic signed [37:0] prod;
    logic signed [37:0] res;
    atten = {1'b0, chan} + {1'b0, master};
    shift = atten / `AVC_CODES_PER_SHIFT;
    ext   = 24'(smp) <<< `AVC_HEADROOM_SHIFT;
    ext   = ext >>> shift;
    prod  = 38'(ext) * 38'(signed'({1'b0, ramp}));
    res   = prod >>> `AVC_RAMP_SHIFT;
    if (master == `AVC_MASTER_HARD_MUTE)
      return 16'sh0000;
    else if (res > 38'sh0_0000_7FFF)
      return 16'sh7FFF;
    else if (res < -38'sh0_0000_8000)
      return -16'sh8000;
    else
      return res[15:0];
  endfunction

  // Register read decode.
  function automatic logic [31:0] read_word(input logic [`AVC_ADDR_W-1:0] addr);
    logic [31:0] res;
    res = '0;
    unique case (addr)
      `AVC_ADDR_LEFT_GAIN:   res[7:0] = left_gain_reg;
      `AVC_ADDR_RIGHT_GAIN:  res[7:0] = right_gain_reg;
      `AVC_ADDR_MASTER_GAIN: res[7:0] = master_gain_reg;
      `AVC_ADDR_CONTROL:     res      = control_reg;
      `AVC_ADDR_STATUS:
      begin
        res[`AVC_STAT_HPD_BIT]  = strap_mode;
        res[`AVC_STAT_CLK_BIT]  = CLOCK_FROM_MASTER_PIN;
        res[`AVC_STAT_SRC_BIT]  = SOURCE_IS_SERIAL;
        res[`AVC_STAT_MODE_BIT] = MODULATION_PHASE_SHIFT;
        res[`AVC_STAT_MUTE_BIT] = muted;
        res[`AVC_STAT_RAMP_LSB +: `AVC_RAMP_W] = ramp_reg;
      end
      default:               res = '0;
    endcase
    return res;
  endfunction

  function automatic logic is_mapped(input logic [`AVC_ADDR_W-1:0] addr);
    return addr == `AVC_ADDR_LEFT_GAIN || addr == `AVC_ADDR_RIGHT_GAIN ||
           addr == `AVC_ADDR_MASTER_GAIN || addr == `AVC_ADDR_CONTROL ||
           addr == `AVC_ADDR_STATUS;
  endfunction

  // Pin synchronisers; only the second stage and its delayed copy are read.
  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
    end
    else
    begin
      sync1_reg <= {MUTE, BIT_CLOCK_OUT_PIN, FRAME_CLOCK_OUT_PIN, SCL, SDA,
                    CLOCK_SOURCE_SELECT, HOST_PORT_DISABLE};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  assign strap_mode  = sync2_reg[HPD];
  assign vol_both    = sync2_reg[VUP] && sync2_reg[VDN];
  assign vol_up_edge = sync2_reg[VUP] && !sync3_reg[VUP];
  assign vol_dn_edge = sync2_reg[VDN] && !sync3_reg[VDN];

  // AXI4-Lite write channels; address and data are taken in either order.
  assign wr_fire   = aw_got_reg && w_got_reg && !S_AXI_BVALID;
  assign wr_mapped = is_mapped(wr_addr_reg);

  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY  <= 1'b1;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `AVC_RESP_OKAY;
      aw_got_reg    <= 1'b0;
      w_got_reg     <= 1'b0;
      wr_addr_reg   <= '0;
      wr_data_reg   <= '0;
      wr_strb_reg   <= '0;
    end
    else
    begin
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        wr_addr_reg   <= S_AXI_AWADDR[`AVC_ADDR_W-1:0];
        aw_got_reg    <= 1'b1;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        wr_data_reg  <= S_AXI_WDATA;
        wr_strb_reg  <= S_AXI_WSTRB;
        w_got_reg    <= 1'b1;
        S_AXI_WREADY <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_got_reg   <= 1'b0;
        w_got_reg    <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wr_mapped ? `AVC_RESP_OKAY : `AVC_RESP_SLVERR;
      end
      if (S_AXI_BVALID && S_AXI_BREADY)
      begin
        S_AXI_BVALID  <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY  <= 1'b1;
      end
    end
  end

  // AXI4-Lite read channel; data are sampled at the address handshake.
  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= '0;
      S_AXI_RRESP   <= `AVC_RESP_OKAY;
    end
    else if (S_AXI_ARVALID && S_AXI_ARREADY)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b1;
      S_AXI_RDATA   <= read_word(S_AXI_ARADDR[`AVC_ADDR_W-1:0]);
      S_AXI_RRESP   <= is_mapped(S_AXI_ARADDR[`AVC_ADDR_W-1:0]) ?
                       `AVC_RESP_OKAY : `AVC_RESP_SLVERR;
    end
    else if (S_AXI_RVALID && S_AXI_RREADY)
    begin
      S_AXI_RVALID  <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

  // Channel volumes: pins own them while the host port is disabled.
  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      left_gain_reg  <= `AVC_GAIN_POWERUP;
      right_gain_reg <= `AVC_GAIN_POWERUP;
    end
    else if (strap_mode)
    begin
      if (vol_both)
      begin
        left_gain_reg  <= `AVC_GAIN_UNITY;
        right_gain_reg <= `AVC_GAIN_UNITY;
      end
      else if (vol_up_edge)
      begin
        left_gain_reg  <= step_gain(left_gain_reg, 1'b1);
        right_gain_reg <= step_gain(right_gain_reg, 1'b1);
      end
      else if (vol_dn_edge)
      begin
        left_gain_reg  <= step_gain(left_gain_reg, 1'b0);
        right_gain_reg <= step_gain(right_gain_reg, 1'b0);
      end
    end
    else if (wr_fire && wr_strb_reg[0])
    begin
      if (wr_addr_reg == `AVC_ADDR_LEFT_GAIN)
        left_gain_reg <= wr_data_reg[7:0];
      if (wr_addr_reg == `AVC_ADDR_RIGHT_GAIN)
        right_gain_reg <= wr_data_reg[7:0];
    end
  end

  // Master offset and control word.
  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      master_gain_reg <= `AVC_MASTER_RESET;
      control_reg     <= `AVC_CTRL_RESET;
    end
    else if (wr_fire)
    begin
      if (wr_addr_reg == `AVC_ADDR_MASTER_GAIN && wr_strb_reg[0])
        master_gain_reg <= wr_data_reg[7:0];
      if (wr_addr_reg == `AVC_ADDR_CONTROL)
      begin
        control_reg <= merge(control_reg, wr_data_reg, wr_strb_reg);
        control_reg[`AVC_CTRL_SRATE_LSB +: `AVC_RATE_W] <=
          clamp_rate(merge(control_reg, wr_data_reg, wr_strb_reg)
                     [`AVC_CTRL_SRATE_LSB +: `AVC_RATE_W], `AVC_RATE_SERIAL_MAX);
        control_reg[`AVC_CTRL_ARATE_LSB +: `AVC_RATE_W] <=
          clamp_rate(merge(control_reg, wr_data_reg, wr_strb_reg)
                     [`AVC_CTRL_ARATE_LSB +: `AVC_RATE_W], `AVC_RATE_ADC_MAX);
      end
    end
  end

  // Source and modulation mode come from the straps when the host port is off.
  always_comb
  begin
    if (strap_mode)
    begin
      src_sel  = sync2_reg[PDATA] ? avc_pkg::AVC_SRC_SERIAL : avc_pkg::AVC_SRC_ADC;
      mode_sel = sync2_reg[PCLK] ? avc_pkg::AVC_MODE_PHASE : avc_pkg::AVC_MODE_BINARY;
    end
    else
    begin
      src_sel  = control_reg[`AVC_CTRL_SRC_BIT] ? avc_pkg::AVC_SRC_SERIAL :
                                                  avc_pkg::AVC_SRC_ADC;
      mode_sel = control_reg[`AVC_CTRL_MODE_BIT] ? avc_pkg::AVC_MODE_PHASE :
                                                   avc_pkg::AVC_MODE_BINARY;
    end
  end

  assign muted = control_reg[`AVC_CTRL_MUTE_BIT] || sync2_reg[PMUTE];

  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      CLOCK_FROM_MASTER_PIN  <= 1'b0;
      MODULATION_PHASE_SHIFT <= 1'b0;
      SOURCE_IS_SERIAL       <= 1'b0;
      SERIAL_RATE            <= '0;
      ADC_RATE               <= '0;
    end
    else
    begin
      CLOCK_FROM_MASTER_PIN  <= sync2_reg[CSEL];
      MODULATION_PHASE_SHIFT <= (mode_sel == avc_pkg::AVC_MODE_PHASE);
      SOURCE_IS_SERIAL       <= (src_sel == avc_pkg::AVC_SRC_SERIAL);
      SERIAL_RATE            <= control_reg[`AVC_CTRL_SRATE_LSB +: `AVC_RATE_W];
      ADC_RATE               <= control_reg[`AVC_CTRL_ARATE_LSB +: `AVC_RATE_W];
    end
  end

  // The unselected source is not stalled: live audio is dropped, not queued.
  assign in_valid = (src_sel == avc_pkg::AVC_SRC_SERIAL) ? SERIAL_VALID : ADC_VALID;
  assign in_frame = (src_sel == avc_pkg::AVC_SRC_SERIAL) ? SERIAL_FRAME : ADC_FRAME;
  assign accept   = in_valid && core_s.ready;

  // Soft mute ramp moves one step per accepted sample in either direction.
  always_ff @(posedge CLK)
  begin
    if (!NRST)
      ramp_reg <= `AVC_RAMP_W'(`AVC_RAMP_SAMPLES);
    else if (accept)
    begin
      if (muted && ramp_reg != '0)
        ramp_reg <= ramp_reg - `AVC_RAMP_W'(1);
      else if (!muted && ramp_reg != `AVC_RAMP_W'(`AVC_RAMP_SAMPLES))
        ramp_reg <= ramp_reg + `AVC_RAMP_W'(1);
    end
  end

  assign core_s.valid      = in_valid;
  assign core_s.data.left  = scale(in_frame.left, left_gain_reg,
                                   master_gain_reg, ramp_reg);
  assign core_s.data.right = scale(in_frame.right, right_gain_reg,
                                   master_gain_reg, ramp_reg);

  avc_frame_buffer u_buffer
  (
    .CLK   (CLK),
    .NRST  (NRST),
    .in_s  (core_s),
    .out_s (out_s)
  );

  assign AUDIO_READY  = core_s.ready;
  assign OUT_VALID    = out_s.valid;
  assign OUT_FRAME    = out_s.data;
  assign out_s.ready  = OUT_READY;

endmodule

// ===== design/avc_cfg.svh
// Constants for the audio volume and strap control block.
`ifndef AVC_CFG_SVH
`define AVC_CFG_SVH

// Register byte addresses.
`define AVC_ADDR_LEFT_GAIN    8'h00
`define AVC_ADDR_RIGHT_GAIN   8'h04
`define AVC_ADDR_MASTER_GAIN  8'h08
`define AVC_ADDR_CONTROL      8'h0C
`define AVC_ADDR_STATUS       8'h10
`define AVC_ADDR_W            8

// Control register fields.
`define AVC_CTRL_MUTE_BIT     0
`define AVC_CTRL_SRC_BIT      1
`define AVC_CTRL_MODE_BIT     2
`define AVC_CTRL_SRATE_LSB    8
`define AVC_CTRL_ARATE_LSB    12
`define AVC_RATE_W            4

// Status register fields.
`define AVC_STAT_HPD_BIT      0
`define AVC_STAT_CLK_BIT      1
`define AVC_STAT_SRC_BIT      2
`define AVC_STAT_MODE_BIT     3
`define AVC_STAT_MUTE_BIT     4
`define AVC_STAT_RAMP_LSB     16

// Gain codes and reset values.
`define AVC_GAIN_UNITY        8'h48
`define AVC_GAIN_POWERUP      8'hC0
`define AVC_GAIN_MIN_CODE     8'h00
`define AVC_GAIN_MAX_CODE     8'hFF
`define AVC_MASTER_RESET      8'h00
`define AVC_MASTER_HARD_MUTE  8'hFF
`define AVC_CTRL_RESET        32'h0000_0000

// Sample rate codes: 0 is 8 kHz up to 14 for 192 kHz, 8 is 48 kHz.
`define AVC_RATE_SERIAL_MAX   4'hE
`define AVC_RATE_ADC_MAX      4'h8

// Gain arithmetic: codes per 6 dB and the +36 dB headroom as a shift.
`define AVC_CODES_PER_SHIFT   9'h00C
`define AVC_HEADROOM_SHIFT    6
`define AVC_RAMP_SAMPLES      4096
`define AVC_RAMP_W            13
`define AVC_RAMP_SHIFT        12

// AXI responses.
`define AVC_RESP_OKAY         2'b00
`define AVC_RESP_SLVERR       2'b10

`endif

// ===== design/avc_pkg.sv
// Types shared by the audio volume and strap control block.
package avc_pkg;

  typedef logic signed [15:0] avc_sample_t;

  typedef struct packed {
    avc_sample_t left;
    avc_sample_t right;
  } avc_frame_t;

  typedef enum logic {
    AVC_SRC_ADC,
    AVC_SRC_SERIAL
  } avc_src_t;

  typedef enum logic {
    AVC_MODE_BINARY,
    AVC_MODE_PHASE
  } avc_mode_t;

endpackage

// ===== design/avc_stream_if.sv
// Valid/ready stream carrier between the control core and its buffer.
interface avc_stream_if;
  logic                valid;
  logic                ready;
  avc_pkg::avc_frame_t data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ===== design/avc_frame_buffer.sv
// Two-entry buffer whose outputs and input ready all come from flip-flops.
module avc_frame_buffer
(
  // Clock and reset
  input wire logic     CLK,
  input wire logic     NRST,
  // Streams
  avc_stream_if.snk    in_s,
  avc_stream_if.src    out_s
);

  logic                head_valid_reg;
  logic                tail_valid_reg;
  avc_pkg::avc_frame_t head_reg;
  avc_pkg::avc_frame_t tail_reg;
  logic                push;
  logic                pop;

  assign push        = in_s.valid && !tail_valid_reg;
  assign pop         = head_valid_reg && out_s.ready;
  assign in_s.ready  = !tail_valid_reg;
  assign out_s.valid = head_valid_reg;
  assign out_s.data  = head_reg;

  // The tail slot absorbs the word in flight when the receiver stalls.
  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      head_valid_reg <= 1'b0;
      tail_valid_reg <= 1'b0;
      head_reg       <= '0;
      tail_reg       <= '0;
    end
    else
    begin
      if (pop || !head_valid_reg)
      begin
        if (tail_valid_reg)
        begin
          head_reg       <= tail_reg;
          head_valid_reg <= 1'b1;
          tail_valid_reg <= push;
          tail_reg       <= in_s.data;
        end
        else
        begin
          head_reg       <= in_s.data;
          head_valid_reg <= push;
        end
      end
      else if (push)
      begin
        tail_reg       <= in_s.data;
        tail_valid_reg <= 1'b1;
      end
    end
  end

endmodule

// ===== sim/avc_volume_ctrl_sva.sv
// Port-level checker for the audio volume and strap control block.
`include "avc_cfg.svh"
module avc_volume_ctrl_sva
(
  // Clock and reset
  input wire logic                CLK,
  input wire logic                NRST,
  // Register bus handshakes
  input wire logic                S_AXI_AWVALID,
  input wire logic                S_AXI_AWREADY,
  input wire logic                S_AXI_WVALID,
  input wire logic                S_AXI_WREADY,
  input wire logic                S_AXI_BVALID,
  input wire logic                S_AXI_BREADY,
  input wire logic                S_AXI_ARVALID,
  input wire logic                S_AXI_ARREADY,
  input wire logic                S_AXI_RVALID,
  // Straps
  input wire logic                HOST_PORT_DISABLE,
  input wire logic                CLOCK_SOURCE_SELECT,
  input wire logic                SDA,
  input wire logic                SCL,
  // Audio out
  input wire avc_pkg::avc_frame_t OUT_FRAME,
  input wire logic                OUT_VALID,
  input wire logic                OUT_READY,
  // Controls
  input wire logic                CLOCK_FROM_MASTER_PIN,
  input wire logic                MODULATION_PHASE_SHIFT,
  input wire logic                SOURCE_IS_SERIAL,
  input wire logic [3:0]          SERIAL_RATE,
  input wire logic [3:0]          ADC_RATE
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);
  sequence wr_taken;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  // Four stable samples cover two synchroniser stages plus the output register.
  sequence sel_held;
    $stable(CLOCK_SOURCE_SELECT) [*4];
  endsequence
  sequence src_held;
    (HOST_PORT_DISABLE && $stable(SDA)) [*4];
  endsequence
  sequence mode_held;
    (HOST_PORT_DISABLE && $stable(SCL)) [*4];
  endsequence
  clk_select_a: assert property (
    sel_held |-> CLOCK_FROM_MASTER_PIN == CLOCK_SOURCE_SELECT)
    else $error("clock source output does not follow its select");
  strap_source_a: assert property (
    src_held |-> SOURCE_IS_SERIAL == SDA)
    else $error("strapped source does not follow the data pin");
  strap_mode_a: assert property (
    mode_held |-> MODULATION_PHASE_SHIFT == SCL)
    else $error("strapped mode does not follow the clock pin");
  serial_rate_a: assert property (SERIAL_RATE <= `AVC_RATE_SERIAL_MAX)
    else $error("serial rate code beyond 192 kHz");
  adc_rate_a: assert property (ADC_RATE <= `AVC_RATE_ADC_MAX)
    else $error("converter rate code beyond 48 kHz");
  write_answer_a: assert property (wr_taken |=> !S_AXI_WREADY ##1 S_AXI_BVALID && !S_AXI_AWREADY)
    else $error("write response late");
  write_release_a: assert property (
    S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID && S_AXI_AWREADY && S_AXI_WREADY)
    else $error("write channel not freed after response");
  read_answer_a: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY)
    else $error("read data late");
  out_hold_a: assert property (OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_FRAME))
    else $error("output frame changed while stalled");
endmodule
bind avc_volume_ctrl avc_volume_ctrl_sva chk (.*);

// ===== sim/avc_sink_model.sv
// Modulator-side sink that stalls and collects every frame it takes.
module avc_sink_model
(
  // Clock
  input wire logic                CLK,
  // Stream from the block
  input wire avc_pkg::avc_frame_t OUT_FRAME,
  input wire logic                OUT_VALID,
  output logic                    OUT_READY,
  // Long stall request from the bench
  input wire logic                hold
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0]          phase_reg = 3'h0;
  avc_pkg::avc_frame_t got[$];
  // Two idle cycles in five keep the buffer's stall path busy.
  assign OUT_READY = !hold && (phase_reg < 3'h3);
  always @(posedge CLK)
  begin
    phase_reg <= (phase_reg == 3'h4) ? 3'h0 : phase_reg + 3'h1;
    if (OUT_VALID && OUT_READY)
      got.push_back(OUT_FRAME);
  end
endmodule

// ===== sim/avc_volume_ctrl_tb.sv
// Self-checking bench for the audio volume and strap control block.
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module avc_volume_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  int                  n_mismatch = 0;
  int                  checks = 0;
  logic                clk = 1'h0;
  logic                nrst = 1'h0;
  logic [7:0]          awa = 8'h0;
  logic [7:0]          ara = 8'h0;
  logic [31:0]         wd = 32'h0;
  logic [3:0]          ws = 4'hF;
  logic                awv = 1'h0;
  logic                wv = 1'h0;
  logic                br = 1'h1;
  logic                arv = 1'h0;
  logic                hpd = 1'h0;
  logic                css = 1'h0;
  logic                sda = 1'h0;
  logic                scl = 1'h0;
  logic                fr = 1'h0;
  logic                bc = 1'h0;
  logic                mute = 1'h0;
  logic                sv = 1'h0;
  logic                av = 1'h0;
  logic                hold = 1'h0;
  logic [31:0]         sf = 32'h0;
  logic [31:0]         af = 32'h0;
  logic [31:0]         g;
  logic                aw_rdy, w_rdy, bv, ar_rdy, rv, a_rdy, o_v, o_rdy, clk_m, ph, ser;
  logic [1:0]          bresp, rresp;
  logic [31:0]         rdata;
  logic [3:0]          srate, arate;
  avc_pkg::avc_frame_t o_f;

  avc_volume_ctrl u_avc_volume_ctrl
  (
    .CLK(clk), .NRST(nrst),
    .S_AXI_AWADDR({24'h0, awa}), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(aw_rdy),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv), .S_AXI_WREADY(w_rdy),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br),
    .S_AXI_ARADDR({24'h0, ara}), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(ar_rdy),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(1'h1),
    .HOST_PORT_DISABLE(hpd), .CLOCK_SOURCE_SELECT(css), .SDA(sda), .SCL(scl),
    .FRAME_CLOCK_OUT_PIN(fr), .BIT_CLOCK_OUT_PIN(bc), .MUTE(mute),
    .SERIAL_FRAME(sf), .SERIAL_VALID(sv), .ADC_FRAME(af), .ADC_VALID(av),
    .AUDIO_READY(a_rdy), .OUT_FRAME(o_f), .OUT_VALID(o_v), .OUT_READY(o_rdy),
    .CLOCK_FROM_MASTER_PIN(clk_m), .MODULATION_PHASE_SHIFT(ph),
    .SOURCE_IS_SERIAL(ser), .SERIAL_RATE(srate), .ADC_RATE(arate)
  );
  avc_sink_model sink (.CLK(clk), .OUT_FRAME(o_f), .OUT_VALID(o_v), .OUT_READY(o_rdy),
                       .hold(hold));

  always #5 clk = ~clk;

  task automatic conclude;
    if (n_mismatch == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    int n;
    n = 0;
    awa <= a;
    wd <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    do
    begin
      @(posedge clk);
      n++;
      if (aw_rdy) awv <= 1'h0;
      if (w_rdy) wv <= 1'h0;
    end
    while (!(bv && br) && n < 50);
    `CHK(bresp, e)
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    n = 0;
    ara <= a;
    arv <= 1'h1;
    do
    begin
      @(posedge clk);
      n++;
      if (ar_rdy) arv <= 1'h0;
    end
    while (!rv && n < 50);
    `CHK(rdata, e)
    `CHK(rresp, er)
  endtask

  // Both sources offer at once; the unselected one must be ignored.
  task automatic snd(input logic [31:0] f);
    int n;
    n = 0;
    @(posedge clk);
    sf <= f;
    af <= ~f;
    sv <= 1'h1;
    av <= 1'h1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (!a_rdy && n < 50);
    sv <= 1'h0;
    av <= 1'h0;
  endtask

  task automatic pull;
    int n;
    n = 0;
    while (sink.got.size() == 0 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    g = (sink.got.size() > 0) ? sink.got.pop_front() : 32'hX;
  endtask

  task automatic xf(input logic [31:0] f, input logic [31:0] e);
    snd(f);
    pull;
    `CHK(g, e)
  endtask

  task automatic pulse(input logic up, input logic dn);
    fr <= up;
    bc <= dn;
    repeat (4) @(posedge clk);
    fr <= 1'h0;
    bc <= 1'h0;
    repeat (4) @(posedge clk);
  endtask

  task automatic t_reset;
    rd(8'h00, 32'hC0, 2'h0);
    rd(8'h04, 32'hC0, 2'h0);
    rd(8'h08, 32'h0, 2'h0);
    rd(8'h0C, 32'h0, 2'h0);
    @(posedge clk);
    `CHK({a_rdy, o_v, bv, rv}, 4'h8)
  endtask

  task automatic t_regs;
    wr(8'h20, 32'h5, 2'h2);
    rd(8'h20, 32'h0, 2'h2);
    wr(8'h10, 32'hFFFF_FFFF, 2'h0);
    ws <= 4'hE;
    wr(8'h08, 32'h33, 2'h0);
    ws <= 4'hF;
    rd(8'h08, 32'h0, 2'h0);
    wr(8'h0C, 32'h0000_FF06, 2'h0);
    rd(8'h0C, 32'h0000_8E06, 2'h0);
    `CHK({ser, ph, srate, arate}, 10'h3E8)
  endtask

  task automatic t_gain;
    wr(8'h0C, 32'h2, 2'h0);
    wr(8'h00, 32'h48, 2'h0);
    wr(8'h04, 32'h48, 2'h0);
    xf(32'h1234_F000, 32'h1234_F000);
    wr(8'h00, 32'h0, 2'h0);
    wr(8'h08, 32'h18, 2'h0);
    xf(32'h0010_0100, 32'h0100_0040);
    wr(8'h04, 32'hFF, 2'h0);
    wr(8'h08, 32'h0, 2'h0);
    xf(32'h1000_7FFF, 32'h7FFF_0000);
    wr(8'h0C, 32'h0, 2'h0);
    wr(8'h00, 32'h48, 2'h0);
    wr(8'h04, 32'h48, 2'h0);
    xf(32'h1234_5678, 32'hEDCB_A987);
    wr(8'h08, 32'hFF, 2'h0);
    xf(32'h1234_5678, 32'h0);
    wr(8'h08, 32'h0, 2'h0);
    wr(8'h0C, 32'h2, 2'h0);
  endtask

  task automatic t_buf;
    int k;
    k = 0;
    hold <= 1'h1;
    @(posedge clk);
    sf <= 32'h1;
    sv <= 1'h1;
    repeat (12)
    begin
      @(posedge clk);
      if (a_rdy)
      begin
        k++;
        sf <= sf + 32'h1;
      end
    end
    sv <= 1'h0;
    `CHK(k, 2)
    hold <= 1'h0;
    pull;
    `CHK(g, 32'h1)
    pull;
    `CHK(g, 32'h2)
  endtask

  task automatic t_strap;
    css <= 1'h1;
    wr(8'h00, 32'h1, 2'h0);
    wr(8'h04, 32'h48, 2'h0);
    repeat (4) @(posedge clk);
    `CHK(clk_m, 1'h1)
    css <= 1'h0;
    hpd <= 1'h1;
    sda <= 1'h1;
    scl <= 1'h1;
    repeat (4) @(posedge clk);
    `CHK(clk_m, 1'h0)
    `CHK({ser, ph}, 2'h3)
    sda <= 1'h0;
    scl <= 1'h0;
    repeat (4) @(posedge clk);
    `CHK({ser, ph}, 2'h0)
    pulse(1'h1, 1'h0);
    pulse(1'h1, 1'h0);
    pulse(1'h0, 1'h1);
    rd(8'h00, 32'h1, 2'h0);
    rd(8'h04, 32'h47, 2'h0);
    pulse(1'h1, 1'h1);
    rd(8'h00, 32'h48, 2'h0);
    wr(8'h00, 32'h10, 2'h0);
    rd(8'h00, 32'h48, 2'h0);
    hpd <= 1'h0;
    repeat (4) @(posedge clk);
  endtask

  // The midway sample must be neither the unmuted level nor silent: a gradual fade.
  task automatic t_mute;
    mute <= 1'h1;
    for (int i = 0; i < 4200; i++)
    begin
      snd(32'h4000_4000);
      pull;
      if (i == 2048) `CHK((g != 32'h0) && (g != 32'h4000_4000), 1'h1)
    end
    `CHK(g, 32'h0)
    rd(8'h10, 32'h14, 2'h0);
  endtask

  initial
  begin
    repeat (80000) @(posedge clk);
    n_mismatch++;
    conclude;
  end

  initial
  begin
    repeat (3) @(posedge clk);
    nrst <= 1'h1;
    t_reset;
    t_regs;
    t_gain;
    t_buf;
    t_strap;
    t_mute;
    conclude;
  end
endmodule
